//--- adc_control_word.sv
`timescale 1ns/1ps
`include "cfg_word_defs.svh"
module adc_control_word
    import cfg_word_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // mode
    input wire logic master_reset_i,
    input wire logic control_source_select_i,
    input wire logic serial_mode_i,
    // parallel port
    input wire logic write_strobe_n_i,
    input wire logic [15:0] par_data_i,
    input wire logic par_high_half_i,
    // serial port
    input wire logic serial_frame_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_in_i,
    output logic serial_out_lines_o,
    output logic read_back_active_o,
    // status from converter core
    input wire logic conv_busy_i,
    input wire logic conv_done_i,
    input wire logic int_clk_i,
    // decoded controls
    output logic [31:0] config_word_o,
    output logic [2:0] pair_enable_o,
    output logic [2:0] pair_span_2x_o,
    output logic [2:0] pair_power_down_o,
    output logic internal_source_on_o,
    output logic reference_buffer_off_o,
    output logic interleaved_start_mode_o,
    output logic auto_sleep_o,
    output logic reference_level_3v_o,
    output logic conversion_clock_source_o,
    output logic conversion_clock_export_o,
    output logic [9:0] reference_trim_code_o,
    output logic conv_abort_o,
    // shared pins
    output logic conv_flag_o,
    output logic clock_pin_o,
    output logic clock_pin_oe_o
);
    logic [31:0] config_word_r;
    logic [31:0] config_word_nxt;
    logic wr_n_s;
    logic wr_n_d_r;
    logic frame_n_s;
    logic sclk_s;
    logic sdi_s;
    logic sclk_d_r;
    logic hw_mode_s;
    logic [31:0] shift_in_r;
    logic [31:0] shift_out_r;
    logic [5:0] fall_cnt_r;
    logic read_back_frame_r;
    logic int_pending_r;
    logic sclk_fall;
    logic wr_rise;
    logic ser_load;
    ser_state_t ser_state_r;

    // ************************************************
    // pin synchronisers
    // ************************************************
    // idle levels: strobe and frame high, others low
    pin_sync #(
        .WIDTH(5),
        .RESET_VAL(5'h18)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({write_strobe_n_i, serial_frame_n_i, serial_clk_i,
            serial_in_i, control_source_select_i}),
        .level_o({wr_n_s, frame_n_s, sclk_s, sdi_s, hw_mode_s})
    );

    function automatic logic [31:0] clean_word(input logic [31:0] w);
        clean_word = w & `CW_ZERO_MASK;
    endfunction : clean_word

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wr_n_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
        end else begin
            wr_n_d_r <= wr_n_s;
            sclk_d_r <= sclk_s;
        end
    end

    assign wr_rise = wr_n_s && !wr_n_d_r;
    assign sclk_fall = !sclk_s && sclk_d_r;

    // ************************************************
    // serial frame
    // ************************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || master_reset_i) begin
            ser_state_r <= SER_IDLE;
            fall_cnt_r <= 6'h00;
            shift_in_r <= 32'h0000_0000;
            shift_out_r <= 32'h0000_0000;
            read_back_frame_r <= 1'b0;
        end else begin
            case (ser_state_r)
                SER_IDLE: begin
                    if (!frame_n_s) begin
                        ser_state_r <= SER_SHIFT;
                        fall_cnt_r <= 6'h00;
                        read_back_frame_r <= config_word_r[`CW_READ_BACK];
                        shift_out_r <= config_word_r;
                    end
                end
                SER_SHIFT: begin
                    if (frame_n_s) begin
                        ser_state_r <= SER_IDLE;
                    end else if (sclk_fall) begin
                        shift_in_r <= {shift_in_r[30:0], sdi_s};
                        shift_out_r <= {shift_out_r[30:0], 1'b0};
                        fall_cnt_r <= fall_cnt_r + 6'h01;
                        if (fall_cnt_r == 6'(`CW_SERIAL_BITS - 1)) begin
                            ser_state_r <= SER_DONE;
                        end
                    end
                end
                SER_DONE: begin
                    if (frame_n_s) begin
                        ser_state_r <= SER_IDLE;
                    end
                end
                default: ser_state_r <= SER_IDLE;
            endcase
        end
    end

    // 32nd falling edge of an updating access
    assign ser_load = (ser_state_r == SER_SHIFT) && !frame_n_s && sclk_fall
        && (fall_cnt_r == 6'(`CW_SERIAL_BITS - 1)) && serial_mode_i;

    assign serial_out_lines_o = read_back_frame_r ? shift_out_r[31]
        : 1'b0;
    assign read_back_active_o = read_back_frame_r;

    // ************************************************
    // configuration word
    // ************************************************
    always_comb begin
        config_word_nxt = config_word_r;
        if (!hw_mode_s) begin
            if (ser_load) begin
                if (config_word_r[`CW_FULL_UPDATE]) begin
                    config_word_nxt = {shift_in_r[30:0], sdi_s};
                end else begin
                    config_word_nxt[31:`CW_TOP_LSB] = shift_in_r[30:23];
                end
            end else if (wr_rise && !serial_mode_i) begin
                if (par_high_half_i) begin
                    config_word_nxt[31:16] = par_data_i;
                end else begin
                    config_word_nxt[15:0] = par_data_i;
                end
            end
        end
        config_word_nxt = clean_word(config_word_nxt);
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || master_reset_i) begin
            config_word_r <= `CW_RESET;
        end else begin
            config_word_r <= config_word_nxt;
        end
    end

    assign conv_abort_o = master_reset_i;
    assign config_word_o = config_word_r;

    // ************************************************
    // decoded fields
    // ************************************************
    always_comb begin
        pair_enable_o = hw_mode_s ? 3'h0
            : config_word_r[`CW_PAIR_EN_LSB +: 3];
        pair_span_2x_o = hw_mode_s ? 3'h0 : config_word_r[`CW_SPAN_LSB +: 3];
        internal_source_on_o = !hw_mode_s && config_word_r[`CW_REF_SRC];
        reference_buffer_off_o = !hw_mode_s && config_word_r[`CW_REF_BUF_OFF];
        conversion_clock_source_o = !hw_mode_s && config_word_r[`CW_CLK_SRC];
        interleaved_start_mode_o = conversion_clock_source_o
            && config_word_r[`CW_INTERLEAVE];
        conversion_clock_export_o = !hw_mode_s
            && config_word_r[`CW_CLK_EXPORT];
    end

    assign pair_power_down_o = config_word_r[`CW_PD_LSB +: 3];
    assign auto_sleep_o = config_word_r[`CW_AUTO_SLEEP];
    assign reference_level_3v_o = config_word_r[`CW_REF_LEVEL];
    assign reference_trim_code_o = config_word_r[`CW_TRIM_MSB:0];

    // ************************************************
    // flag and clock pins
    // ************************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || master_reset_i) begin
            int_pending_r <= 1'b0;
        end else if (conv_done_i) begin
            int_pending_r <= 1'b1;
        end else if (!frame_n_s || wr_rise) begin
            int_pending_r <= 1'b0;
        end
    end

    always_comb begin
        if (config_word_r[`CW_FLAG_MODE]) begin
            conv_flag_o = config_word_r[`CW_FLAG_POL] ? int_pending_r
                : !int_pending_r;
        end else begin
            conv_flag_o = config_word_r[`CW_FLAG_POL] ? !conv_busy_i
                : conv_busy_i;
        end
    end

    assign clock_pin_oe_o = conversion_clock_export_o
        && !conversion_clock_source_o;
    assign clock_pin_o = clock_pin_oe_o ? int_clk_i : 1'b0;

    // ************************************************
    // checks
    // ************************************************
    sequence s_partial_load;
        ser_load && !config_word_r[`CW_FULL_UPDATE] && !hw_mode_s;
    endsequence

    AST_UNUSED_ZERO: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        config_word_r[`CW_UNUSED_HI] == 1'b0
        && config_word_r[`CW_UNUSED_LO] == 1'b0)
        else $error("unused bits not zero");
    AST_RESET_LOAD: assert property (@(posedge sys_clk_i)
        master_reset_i |=> config_word_r == `CW_RESET)
        else $error("reset did not load default");
    AST_HW_FREEZE: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i || master_reset_i)
        hw_mode_s |=> config_word_r == $past(config_word_r))
        else $error("word changed in hardware mode");
    AST_HW_IGNORE: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        hw_mode_s |-> pair_enable_o == 3'h0 && !conversion_clock_source_o)
        else $error("ignored fields active in hardware mode");
    AST_PART_UPDATE: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i || master_reset_i)
        s_partial_load
        |=> config_word_r[23:0] == $past(config_word_r[23:0]))
        else $error("partial update touched low bits");
    AST_ENABLE_MAP: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        !hw_mode_s |-> pair_enable_o == config_word_r[31:29])
        else $error("pair enable mismatch");
    AST_FLAG_BUSY: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        !config_word_r[`CW_FLAG_MODE] |-> conv_flag_o ==
        (conv_busy_i ^ config_word_r[`CW_FLAG_POL]))
        else $error("busy flag level wrong");
    AST_TRIM_MAP: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i)
        master_reset_i |=> reference_trim_code_o == 10'h3ff)
        else $error("trim code not all ones after reset");
endmodule : adc_control_word

//--- cfg_word_defs.svh
`ifndef CFG_WORD_DEFS_SVH
`define CFG_WORD_DEFS_SVH
// Notes on behaviour
// - pair enable bits include pair in conversion
// - span bit clear 4x ref, set 2x
// - internal reference on only when bit set
// - buffer bit set turns buffers off
// - auto-sleep bit enables nap after conversion
// - flag mode: busy when clear, interrupt set
// - polarity bit swaps busy and interrupt levels
// - unused bits always hold zero
// - reference level 2.5 V clear, 3 V set
// - read-back bit shifts word out next access
// - serial writes top byte unless full update
// - clock source internal clear, external set
// - export bit drives internal clock on pin when clock source bit clear
// - trim code low ten bits, resets to ones
// - update on write strobe rise or 32nd fall
// - word changes only in software mode or on reset
// - master reset loads default word

// ************************************************
// field positions
// ************************************************
`define CW_PAIR_EN_LSB 29
`define CW_SPAN_LSB 26
`define CW_REF_SRC 25
`define CW_REF_BUF_OFF 24
`define CW_INTERLEAVE 23
`define CW_AUTO_SLEEP 22
`define CW_FLAG_MODE 21
`define CW_FLAG_POL 20
`define CW_UNUSED_HI 19
`define CW_REF_LEVEL 18
`define CW_READ_BACK 17
`define CW_FULL_UPDATE 16
`define CW_PD_LSB 13
`define CW_UNUSED_LO 12
`define CW_CLK_SRC 11
`define CW_CLK_EXPORT 10
`define CW_TRIM_MSB 9
`define CW_TOP_LSB 24

// ************************************************
// reset value and masks
// ************************************************
`define CW_RESET 32'h0000_03ff
`define CW_ZERO_MASK 32'hfff7_efff
`define CW_SERIAL_BITS 32
`endif

//--- cfg_word_pkg.sv
package cfg_word_pkg;
    typedef enum logic [2:0] {
        SER_IDLE = 3'b001,
        SER_SHIFT = 3'b010,
        SER_DONE = 3'b100
    } ser_state_t;
endpackage : cfg_word_pkg

//--- host_model.sv
`timescale 1ns/1ps
`include "cfg_word_defs.svh"
module host_model (
    // clock
    input wire logic sys_clk_i,
    // parallel port
    output logic write_strobe_n_o,
    output logic [15:0] par_data_o,
    output logic par_high_half_o,
    // serial port
    output logic serial_frame_n_o,
    output logic serial_clk_o,
    output logic serial_in_o,
    input wire logic serial_out_lines_i
);
    // ************************************************
    // host writes
    // ************************************************
    initial begin
        write_strobe_n_o = 1'b1;
        par_data_o = 16'h0000;
        par_high_half_o = 1'b0;
        serial_frame_n_o = 1'b1;
        serial_clk_o = 1'b0;
        serial_in_o = 1'b0;
    end
    function automatic logic [31:0] legal(input logic [31:0] w);
        logic [31:0] v;
        v = w & `CW_ZERO_MASK;
        v[23] = v[23] & v[11];
        v[31:29] = v[31:29] & ~v[15:13];
        return v;
    endfunction : legal
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    // low half first, then high half
    task automatic par_word(input logic [31:0] w, input logic raw);
        logic [31:0] v;
        v = raw ? w : legal(w);
        for (int h = 0; h < 2; h++) begin
            tick(1);
            par_high_half_o <= h[0];
            par_data_o <= h[0] ? v[31:16] : v[15:0];
            tick(1);
            write_strobe_n_o <= 1'b0;
            tick(8);
            write_strobe_n_o <= 1'b1;
            tick(8);
            par_data_o <= ~par_data_o;
        end
    endtask : par_word
    // msb first, sampled on falling clock
    task automatic ser_frame(input logic [31:0] w, input int n,
        output logic [31:0] got);
        logic [31:0] v;
        v = legal(w);
        got = 32'h0000_0000;
        tick(1);
        serial_frame_n_o <= 1'b0;
        tick(6);
        for (int i = 31; i > 31 - n; i--) begin
            serial_in_o <= v[i];
            tick(1);
            serial_clk_o <= 1'b1;
            tick(6);
            got[i] = serial_out_lines_i;
            serial_clk_o <= 1'b0;
            tick(6);
        end
        serial_frame_n_o <= 1'b1;
        serial_in_o <= ~serial_in_o;
        tick(8);
    endtask : ser_frame
endmodule : host_model

//--- pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // pins
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // refuse a width that the stages cannot serve
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync width must be positive");
        end
    endgenerate

    // three stages, change taken when last two agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    s1_r[g] <= RESET_VAL[g];
                    s2_r[g] <= RESET_VAL[g];
                    s3_r[g] <= RESET_VAL[g];
                    level_o[g] <= RESET_VAL[g];
                end else begin
                    s1_r[g] <= pin_i[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        level_o[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync

//--- test_adc_control_word.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        errors++; \
        $display("ERROR %0t: got %h want %h", $time, a, b); \
    end \
end
module test_adc_control_word import cfg_word_pkg::*;;
    // ************************************************
    // bench
    // ************************************************
    logic sys_clk_i, sys_rst_i, master_reset_i, control_source_select_i;
    logic serial_mode_i, write_strobe_n_i, par_high_half_i;
    logic serial_frame_n_i, serial_clk_i, serial_in_i;
    logic conv_busy_i, conv_done_i, int_clk_i;
    logic [15:0] par_data_i;
    logic serial_out_lines_o, read_back_active_o, internal_source_on_o;
    logic reference_buffer_off_o, interleaved_start_mode_o, auto_sleep_o;
    logic reference_level_3v_o, conversion_clock_source_o;
    logic conversion_clock_export_o, conv_abort_o, conv_flag_o;
    logic clock_pin_o, clock_pin_oe_o;
    logic [31:0] config_word_o, got;
    logic [2:0] pair_enable_o, pair_span_2x_o, pair_power_down_o;
    logic [9:0] reference_trim_code_o;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rows [6] = '{32'he000_0000, 32'h1f00_0c00, 32'h0080_0800,
        32'h0050_e400, 32'h0004_0155, 32'h0000_0000};
    adc_control_word uut (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .master_reset_i(master_reset_i),
        .control_source_select_i(control_source_select_i),
        .serial_mode_i(serial_mode_i),
        .write_strobe_n_i(write_strobe_n_i),
        .par_data_i(par_data_i),
        .par_high_half_i(par_high_half_i),
        .serial_frame_n_i(serial_frame_n_i),
        .serial_clk_i(serial_clk_i),
        .serial_in_i(serial_in_i),
        .serial_out_lines_o(serial_out_lines_o),
        .read_back_active_o(read_back_active_o),
        .conv_busy_i(conv_busy_i),
        .conv_done_i(conv_done_i),
        .int_clk_i(int_clk_i),
        .config_word_o(config_word_o),
        .pair_enable_o(pair_enable_o),
        .pair_span_2x_o(pair_span_2x_o),
        .pair_power_down_o(pair_power_down_o),
        .internal_source_on_o(internal_source_on_o),
        .reference_buffer_off_o(reference_buffer_off_o),
        .interleaved_start_mode_o(interleaved_start_mode_o),
        .auto_sleep_o(auto_sleep_o),
        .reference_level_3v_o(reference_level_3v_o),
        .conversion_clock_source_o(conversion_clock_source_o),
        .conversion_clock_export_o(conversion_clock_export_o),
        .reference_trim_code_o(reference_trim_code_o),
        .conv_abort_o(conv_abort_o),
        .conv_flag_o(conv_flag_o),
        .clock_pin_o(clock_pin_o),
        .clock_pin_oe_o(clock_pin_oe_o)
    );
    host_model host (
        .sys_clk_i(sys_clk_i),
        .write_strobe_n_o(write_strobe_n_i),
        .par_data_o(par_data_i),
        .par_high_half_o(par_high_half_i),
        .serial_frame_n_o(serial_frame_n_i),
        .serial_clk_o(serial_clk_i),
        .serial_in_o(serial_in_i),
        .serial_out_lines_i(serial_out_lines_o)
    );
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        int_clk_i <= ~int_clk_i;
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("%0d checks, %0d errors", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk_dec(input logic [31:0] w);
        logic s;
        host.tick(6);
        @(negedge sys_clk_i);
        s = !control_source_select_i;
        `CHK(config_word_o, w)
        `CHK(pair_enable_o, w[31:29] & {3{s}})
        `CHK(pair_span_2x_o, w[28:26] & {3{s}})
        `CHK(internal_source_on_o, w[25] & s)
        `CHK(reference_buffer_off_o, w[24] & s)
        `CHK(interleaved_start_mode_o, w[23] & w[11] & s)
        `CHK(auto_sleep_o, w[22])
        `CHK(reference_level_3v_o, w[18])
        `CHK(pair_power_down_o, w[15:13])
        `CHK(conversion_clock_source_o, w[11] & s)
        `CHK(clock_pin_oe_o, w[10] & ~w[11] & s)
        `CHK(conversion_clock_export_o, w[10] & s)
        `CHK(reference_trim_code_o, w[9:0])
        `CHK({config_word_o[19], config_word_o[12]}, 2'b00)
        if (!w[21]) `CHK(conv_flag_o, conv_busy_i ^ w[20])
        if (clock_pin_oe_o === 1'b1) `CHK(clock_pin_o, int_clk_i)
        @(posedge sys_clk_i);
    endtask : chk_dec
    task automatic pw(input logic [31:0] w, input logic raw,
        input logic [31:0] e);
        host.par_word(w, raw);
        chk_dec(e);
    endtask : pw
    task automatic sf(input logic [31:0] w, input int n,
        input logic [31:0] e);
        host.ser_frame(w, n, got);
        chk_dec(e);
    endtask : sf
    task automatic flag_pulse(input logic idle);
        @(negedge sys_clk_i);
        `CHK(conv_flag_o, idle)
        @(posedge sys_clk_i);
        conv_done_i <= 1'b1;
        @(posedge sys_clk_i);
        conv_done_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK(conv_flag_o, ~idle)
        @(posedge sys_clk_i);
    endtask : flag_pulse
    initial begin
        sys_rst_i = 1'b1;
        master_reset_i = 1'b0;
        control_source_select_i = 1'b0;
        serial_mode_i = 1'b0;
        conv_busy_i = 1'b0;
        conv_done_i = 1'b0;
        int_clk_i = 1'b0;
        host.tick(12);
        sys_rst_i <= 1'b0;
        chk_dec(32'h0000_03ff);
        for (int i = 0; i < 6; i++) begin
            conv_busy_i <= i[0];
            pw(rows[i], 1'b0, rows[i]);
            $display("row %0d done", i);
        end
        pw(32'h0008_1000, 1'b1, 32'h0000_0000);
        pw(32'hffc0_0c2a, 1'b0, 32'hffc0_0c2a);
        control_source_select_i <= 1'b1;
        chk_dec(32'hffc0_0c2a);
        pw(32'h0000_0000, 1'b0, 32'hffc0_0c2a);
        control_source_select_i <= 1'b0;
        chk_dec(32'hffc0_0c2a);
        $display("mode test done");
        pw(32'h0020_03ff, 1'b0, 32'h0020_03ff);
        flag_pulse(1'b1);
        pw(32'h0030_03ff, 1'b0, 32'h0030_03ff);
        flag_pulse(1'b0);
        $display("flag test done");
        serial_mode_i <= 1'b1;
        sf(32'ha5f0_0f0f, 32, 32'ha530_03ff);
        pw(32'h0000_0000, 1'b0, 32'ha530_03ff);
        serial_mode_i <= 1'b0;
        pw(32'h0003_0155, 1'b0, 32'h0003_0155);
        serial_mode_i <= 1'b1;
        sf(32'h1234_4678, 32, 32'h1234_4678);
        `CHK(got, 32'h0003_0155)
        `CHK(read_back_active_o, 1'b1)
        sf(32'hffff_ffff, 16, 32'h1234_4678);
        `CHK(got, 32'h0000_0000)
        `CHK(read_back_active_o, 1'b0)
        $display("serial test done");
        master_reset_i <= 1'b1;
        @(negedge sys_clk_i);
        `CHK(conv_abort_o, 1'b1)
        @(posedge sys_clk_i);
        master_reset_i <= 1'b0;
        chk_dec(32'h0000_03ff);
        $display("reset test done");
        give_verdict();
    end
endmodule : test_adc_control_word
